// ==== src/stream_defs.svh ====
`ifndef STREAM_DEFS_SVH
`define STREAM_DEFS_SVH

// channel selection codes
`define CH_X 2'h0
`define CH_XY 2'h1
`define CH_RT 2'h2
`define CH_ALL 2'h3
// rate divisor exponent limit
`define RATE_EXP_MAX 5'h14
// ceiling rate in kHz and derived least period in core clocks
`define CORE_CLK_KHZ 200000
`define CEIL_RATE_KHZ 1250
`define CEIL_PERIOD_CYC (`CORE_CLK_KHZ / `CEIL_RATE_KHZ)
// sample word formats
`define FMT_FLOAT 1'b0
`define FMT_INT 1'b1
// option bits and default
`define OPT_LE_BIT 0
`define OPT_CHK_BIT 1
`define OPT_DEFAULT 2'h2
// destination port
`define PORT_MIN 16'h0400
`define PORT_DEFAULT 16'h0749
// header length in bytes
`define HDR_BYTES 11'h004
// data block lengths per size code
`define BLK_1024 11'h400
`define BLK_512 11'h200
`define BLK_256 11'h100
`define BLK_128 11'h080
// int16 limits and full-scale mapping
`define INT_MAX 16'h7FFF
`define INT_MIN 16'h8000
`define INT_FULL 16'h7333
// fifo depth
`define FIFO_DEPTH 16

`endif

// ==== src/stream_pkg.sv ====
package stream_pkg;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_HDR = 2'b01,
		ST_DATA = 2'b10
	} tx_state_t;
	typedef logic [1:0] chan_sel_t;
endpackage

// ==== src/sample_fifo.sv ====
`timescale 1ns/1ps
`default_nettype none
module sample_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic arst_n,
	// write side
	input wire logic wr_valid,
	output logic wr_ready,
	input wire logic [WIDTH-1:0] wr_data,
	// read side
	output logic rd_valid,
	input wire logic rd_ready,
	output logic [WIDTH-1:0] rd_data,
	// flush
	input wire logic clear
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW:0] wp_q, rp_q;
	wire full = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
	wire empty = (wp_q == rp_q);
	wire do_wr = wr_valid && !full;
	wire do_rd = rd_ready && !empty;
	assign wr_ready = !full;
	assign rd_valid = !empty;
	assign rd_data = mem_q[rp_q[AW-1:0]];
	// storage array
	always_ff @(posedge core_clk) begin
		if (do_wr) begin
			mem_q[wp_q[AW-1:0]] <= wr_data;
		end
	end
	// pointers
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			wp_q <= '0;
			rp_q <= '0;
		end else if (clear) begin
			wp_q <= '0;
			rp_q <= '0;
		end else begin
			if (do_wr) wp_q <= wp_q + 1'b1;
			if (do_rd) rp_q <= rp_q + 1'b1;
		end
	end
	fifo_order_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		full |-> !empty) else $error("fifo full and empty");
endmodule
`default_nettype wire

// ==== src/udp_sample_streamer.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "stream_defs.svh"
module udp_sample_streamer (
	// clock and reset
	input wire logic core_clk,
	input wire logic arst_n,
	// settings from host
	input wire stream_pkg::chan_sel_t output_channel_select,
	input wire logic [4:0] rate_divisor_exponent,
	input wire logic [15:0] ceiling_div_cycles,
	input wire logic sample_word_format,
	input wire logic [1:0] packet_size_select,
	input wire logic [15:0] destination_port_number,
	input wire logic [1:0] byte_order_and_check_bits,
	input wire logic stream_on,
	input wire logic [31:0] enable_source_ip,
	// demodulator outputs, full scale at 2^24
	input wire logic [31:0] x_in,
	input wire logic [31:0] y_in,
	input wire logic [31:0] r_in,
	input wire logic [31:0] theta_in,
	input wire logic [31:0] x_float,
	input wire logic [31:0] y_float,
	input wire logic [31:0] r_float,
	input wire logic [31:0] theta_float,
	// readback
	output logic [4:0] rate_exp_readback,
	output logic streaming,
	output logic overrun,
	// byte stream out
	output logic tx_valid,
	output logic [7:0] tx_data,
	output logic tx_first,
	output logic tx_last,
	input wire logic tx_ready,
	output logic [31:0] dest_ip,
	output logic [15:0] dest_port,
	output logic check_enable
);
	import stream_pkg::*;

	// latched run settings
	logic [1:0] ch_q;
	logic [4:0] exp_q;
	logic fmt_q;
	logic [1:0] pk_q;
	logic [1:0] opt_q;
	logic [15:0] port_q;
	logic [15:0] ceil_q;
	logic on_q;
	logic [31:0] ip_q;
	logic [15:0] seq_q;

	// setting capture at off-to-on edge
	wire start = stream_on && !on_q;
	// clamp exponent and ceiling, bad port falls to default
	wire [4:0] exp_clamp = (rate_divisor_exponent > `RATE_EXP_MAX) ? `RATE_EXP_MAX : rate_divisor_exponent;
	wire [15:0] ceil_clamp = (ceiling_div_cycles < 16'(`CEIL_PERIOD_CYC)) ? 16'(`CEIL_PERIOD_CYC) : ceiling_div_cycles;
	wire [15:0] port_ok = (destination_port_number < `PORT_MIN) ? `PORT_DEFAULT : destination_port_number;

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			on_q <= 1'b0;
			ch_q <= `CH_X;
			exp_q <= 5'h00;
			fmt_q <= `FMT_FLOAT;
			pk_q <= 2'h0;
			opt_q <= `OPT_DEFAULT;
			port_q <= `PORT_DEFAULT;
			ceil_q <= 16'(`CEIL_PERIOD_CYC);
			ip_q <= 32'h0000_0000;
		end else begin
			on_q <= stream_on;
			if (start) begin
				ch_q <= output_channel_select;
				exp_q <= exp_clamp;
				fmt_q <= sample_word_format;
				pk_q <= packet_size_select;
				opt_q <= byte_order_and_check_bits;
				port_q <= port_ok;
				ceil_q <= ceil_clamp;
				ip_q <= enable_source_ip;
			end
		end
	end

	logic [15:0] ceil_cnt_q;
	logic [19:0] div_cnt_q;
	wire ceil_tick = on_q && (ceil_cnt_q == ceil_q - 16'h0001);
	wire [19:0] div_mask = 20'((21'h1 << exp_q) - 21'h1);
	wire strobe = ceil_tick && ((div_cnt_q & div_mask) == 20'h0_0000);
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			ceil_cnt_q <= 16'h0000;
			div_cnt_q <= 20'h0_0000;
		end else if (!on_q) begin
			ceil_cnt_q <= 16'h0000;
			div_cnt_q <= 20'h0_0000;
		end else if (ceil_tick) begin
			ceil_cnt_q <= 16'h0000;
			div_cnt_q <= div_cnt_q + 20'h0_0001;
		end else begin
			ceil_cnt_q <= ceil_cnt_q + 16'h0001;
		end
	end

	function automatic logic [15:0] to_int16(input logic [31:0] v);
		logic signed [47:0] p;
		logic signed [47:0] s;
		p = 48'(signed'(v)) * 48'sd29491;
		s = p >>> 24;
		if (s > 48'sd32767) to_int16 = `INT_MAX;
		else if (s < -48'sd32768) to_int16 = `INT_MIN;
		else to_int16 = s[15:0];
	endfunction

	wire [15:0] xi = to_int16(x_in);
	wire [15:0] yi = to_int16(y_in);
	wire [15:0] ri = to_int16(r_in);
	wire [15:0] ti = to_int16(theta_in);

	// sample set snapped by one strobe
	logic [31:0] set_q [4];
	logic [2:0] set_n_q;
	logic [2:0] set_idx_q;
	logic set_busy_q;
	wire [2:0] n_words = (ch_q == `CH_X) ? 3'd1 : (ch_q == `CH_ALL) ? 3'd4 : 3'd2;
	wire [31:0] w0 = fmt_q ? {16'h0000, (ch_q == `CH_RT) ? ri : xi} : ((ch_q == `CH_RT) ? r_float : x_float);
	wire [31:0] w1 = fmt_q ? {16'h0000, (ch_q == `CH_RT) ? ti : yi} : ((ch_q == `CH_RT) ? theta_float : y_float);
	wire [31:0] w2 = fmt_q ? {16'h0000, ri} : r_float;
	wire [31:0] w3 = fmt_q ? {16'h0000, ti} : theta_float;

	// fifo between sampler and packer
	logic fifo_wr_valid, fifo_wr_ready, fifo_rd_valid, fifo_rd_ready;
	logic [31:0] fifo_rd_data;
	assign fifo_wr_valid = set_busy_q;
	sample_fifo #(.WIDTH(32), .DEPTH(`FIFO_DEPTH)) u_fifo (
		.core_clk(core_clk),
		.arst_n(arst_n),
		.wr_valid(fifo_wr_valid),
		.wr_ready(fifo_wr_ready),
		.wr_data(set_q[set_idx_q[1:0]]),
		.rd_valid(fifo_rd_valid),
		.rd_ready(fifo_rd_ready),
		.rd_data(fifo_rd_data),
		.clear(start)
	);

	// a strobe during a busy set is dropped, not retried
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			for (int i = 0; i < 4; i++) set_q[i] <= 32'h0000_0000;
			set_n_q <= 3'd0;
			set_idx_q <= 3'd0;
			set_busy_q <= 1'b0;
			overrun <= 1'b0;
		end else begin
			if (start) overrun <= 1'b0;
			else if (strobe && set_busy_q) overrun <= 1'b1;
			if (start) begin
				// a new run drops words left from the last one
				set_busy_q <= 1'b0;
				set_idx_q <= 3'd0;
			end else if (strobe && !set_busy_q) begin
				set_q[0] <= w0;
				set_q[1] <= w1;
				set_q[2] <= w2;
				set_q[3] <= w3;
				set_n_q <= n_words;
				set_idx_q <= 3'd0;
				set_busy_q <= 1'b1;
			end else if (set_busy_q && fifo_wr_ready) begin
				set_idx_q <= set_idx_q + 3'd1;
				if (set_idx_q + 3'd1 == set_n_q) set_busy_q <= 1'b0;
			end
		end
	end

	wire [10:0] blk_len = (pk_q == 2'h0) ? `BLK_1024 : (pk_q == 2'h1) ? `BLK_512 :
		(pk_q == 2'h2) ? `BLK_256 : `BLK_128;
	wire [10:0] pay_len = blk_len + `HDR_BYTES;
	wire [2:0] word_bytes = fmt_q ? 3'd2 : 3'd4;

	// packer state
	tx_state_t st_q;
	logic [10:0] byte_cnt_q;
	logic [1:0] wb_q;
	wire out_free = !tx_valid || tx_ready;
	// header: sequence number then channel, format and size codes
	wire [31:0] hdr = {seq_q, 8'h00, ch_q, fmt_q, opt_q[`OPT_CHK_BIT], pk_q, 2'h0};
	wire [1:0] lane = opt_q[`OPT_LE_BIT] ? wb_q : 2'(word_bytes - 3'd1 - {1'b0, wb_q});
	wire [7:0] data_byte = fifo_rd_data[{lane, 3'b000} +: 8];
	wire last_of_word = (3'({1'b0, wb_q}) == word_bytes - 3'd1);
	assign fifo_rd_ready = (st_q == ST_DATA) && out_free && last_of_word;

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_q <= ST_IDLE;
			byte_cnt_q <= 11'h000;
			wb_q <= 2'h0;
			seq_q <= 16'h0000;
			tx_valid <= 1'b0;
			tx_data <= 8'h00;
			tx_first <= 1'b0;
			tx_last <= 1'b0;
		end else begin
			if (tx_valid && tx_ready) tx_valid <= 1'b0;
			case (st_q)
				ST_IDLE: begin
					if (on_q && fifo_rd_valid && out_free) begin
						st_q <= ST_HDR;
						byte_cnt_q <= 11'h000;
					end
				end
				ST_HDR: begin
					if (out_free) begin
						tx_valid <= 1'b1;
						tx_data <= hdr[8 * (3 - byte_cnt_q[1:0]) +: 8];
						tx_first <= (byte_cnt_q == 11'h000);
						tx_last <= 1'b0;
						byte_cnt_q <= byte_cnt_q + 11'h001;
						if (byte_cnt_q == `HDR_BYTES - 11'h001) begin
							st_q <= ST_DATA;
							wb_q <= 2'h0;
						end
					end
				end
				ST_DATA: begin
					if (out_free && fifo_rd_valid) begin
						tx_valid <= 1'b1;
						tx_data <= data_byte;
						tx_first <= 1'b0;
						tx_last <= (byte_cnt_q == pay_len - 11'h001);
						byte_cnt_q <= byte_cnt_q + 11'h001;
						wb_q <= last_of_word ? 2'h0 : wb_q + 2'h1;
						if (byte_cnt_q == pay_len - 11'h001) begin
							st_q <= ST_IDLE;
							seq_q <= seq_q + 16'h0001;
						end
					end
				end
				default: st_q <= ST_IDLE;
			endcase
			if (start) begin
				st_q <= ST_IDLE;
				seq_q <= 16'h0000;
			end
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			rate_exp_readback <= 5'h00;
			streaming <= 1'b0;
			dest_ip <= 32'h0000_0000;
			dest_port <= `PORT_DEFAULT;
			check_enable <= 1'b1;
		end else begin
			rate_exp_readback <= exp_q;
			streaming <= on_q;
			dest_ip <= ip_q;
			dest_port <= port_q;
			check_enable <= opt_q[`OPT_CHK_BIT];
		end
	end

	// assertions
	rate_range_a: assert property (@(posedge core_clk) disable iff (!arst_n) exp_q <= `RATE_EXP_MAX)
		else $error("exponent out of range");
	port_range_a: assert property (@(posedge core_clk) disable iff (!arst_n) port_q >= `PORT_MIN)
		else $error("port below minimum");
	settings_hold_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		(on_q && $past(on_q)) |-> $stable(ch_q) && $stable(fmt_q) && $stable(pk_q)) else $error("settings changed mid-run");
	ceil_limit_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		ceil_q >= 16'(`CEIL_PERIOD_CYC)) else $error("ceiling above limit");
	word_count_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		(strobe && !set_busy_q) |=> set_n_q == ((ch_q == `CH_X) ? 3'd1 : (ch_q == `CH_ALL) ? 3'd4 : 3'd2))
		else $error("wrong word count");
	packet_len_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		(st_q == ST_DATA && out_free && fifo_rd_valid && byte_cnt_q == pay_len - 11'h001) |=> tx_last)
		else $error("last byte missing");
	header_first_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		(st_q == ST_IDLE ##1 st_q == ST_HDR) |-> byte_cnt_q == 11'h000) else $error("header start wrong");
	readback_exp_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		##1 rate_exp_readback == $past(exp_q)) else $error("readback not exponent");
	stop_idle_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		!on_q |-> !strobe) else $error("sample while off");
	check_flag_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		##1 check_enable == $past(opt_q[1])) else $error("check flag wrong");
	start_cov: cover property (@(posedge core_clk) start);
	packet_cov: cover property (@(posedge core_clk) tx_valid && tx_last);
	overrun_cov: cover property (@(posedge core_clk) overrun);
	int_cov: cover property (@(posedge core_clk) tx_valid && tx_first && fmt_q);

	// run-start and conversion guards
	start_clear_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		start |=> !set_busy_q && st_q == ST_IDLE)
		else $error("stale work after start");
	overrun_sticky_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		(overrun && !start) |=> overrun)
		else $error("overrun flag lost");
	full_scale_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		(x_in == 32'h0100_0000) |-> xi == `INT_FULL)
		else $error("full scale not mapped");
	pos_saturate_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		($signed(r_in) >= 32'sh0200_0000) |-> ri == `INT_MAX)
		else $error("positive value not saturated");
	neg_saturate_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		($signed(theta_in) <= -32'sh0200_0000) |-> ti == `INT_MIN)
		else $error("negative value not saturated");
endmodule
`default_nettype wire

// ==== tb/udp_receiver_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module udp_receiver_model (
	// clock and reset
	input wire logic core_clk,
	input wire logic arst_n,
	// byte stream from the streamer
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	input wire logic tx_first,
	input wire logic tx_last,
	output logic tx_ready,
	// control and capture
	input wire logic slow,
	output logic [15:0] pkt_len,
	output logic [47:0] head_bytes,
	output logic [31:0] pkt_count,
	output logic [31:0] last_time
);
	logic [31:0] cyc_q;
	logic [15:0] idx_q;
	wire logic take = tx_valid && tx_ready;
	wire logic [15:0] pos = tx_first ? 16'h0000 : idx_q;
	// keeps pace, slow mode one in four
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			cyc_q <= '0;
			tx_ready <= 1'b0;
		end else begin
			cyc_q <= cyc_q + 32'h0000_0001;
			tx_ready <= !slow || (cyc_q[1:0] == 2'h3);
		end
	end
	// counts bytes, keeps first six, stamps packet ends
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			idx_q <= '0;
			pkt_len <= '0;
			head_bytes <= '0;
			pkt_count <= '0;
			last_time <= '0;
		end else if (take) begin
			idx_q <= pos + 16'h0001;
			if (pos < 16'h0006)
				head_bytes[47 - 8 * pos[2:0] -: 8] <= tx_data;
			if (tx_last) begin
				pkt_len <= pos + 16'h0001;
				pkt_count <= pkt_count + 32'h0000_0001;
				last_time <= cyc_q;
			end
		end
	end
endmodule
`default_nettype wire

// ==== tb/test_udp_sample_streamer.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_udp_sample_streamer;
	import stream_pkg::*;
	typedef struct packed {
		logic [1:0] ch;
		logic fmt;
		logic [1:0] pk;
		logic [15:0] port;
		logic [1:0] opt;
		logic [15:0] len;
		logic [15:0] eport;
		logic [15:0] b45;
	} row_t;
	logic core_clk = 1'b0;
	logic arst_n = 1'b0;
	chan_sel_t ch = 2'h0;
	logic [4:0] rate_exp = 5'h00;
	logic fmt = 1'b0, stream_on = 1'b0, slow = 1'b0;
	logic [1:0] pk = 2'h0, opt = 2'h2;
	logic [15:0] port = 16'h0749;
	logic [31:0] src_ip = 32'h0A00_0010;
	logic [15:0] ceil_cyc = 16'h00A0;
	logic [31:0] x_in = 32'h0100_0000, y_in = 32'h0000_1000;
	logic [31:0] r_in = 32'h7FFF_FFFF, theta_in = 32'h8000_0000;
	logic [4:0] rate_exp_readback;
	logic streaming, overrun, tx_valid, tx_first, tx_last, tx_ready, check_enable;
	logic [7:0] tx_data;
	logic [31:0] dest_ip, pkt_count, last_time, t0;
	logic [15:0] dest_port, pkt_len, seq0;
	logic [47:0] head_bytes;
	int fails = 0, samples_checked = 0, cycles = 0;
	// one row per packet size, every channel code and option
	row_t rows [0:3] = '{
		'{2'h3, 1'b0, 2'h0, 16'h0400, 2'h0, 16'h0404, 16'h0400, 16'h4120},
		'{2'h2, 1'b1, 2'h1, 16'hFFFF, 2'h1, 16'h0204, 16'hFFFF, 16'hFF7F},
		'{2'h1, 1'b0, 2'h2, 16'h03E8, 2'h3, 16'h0104, 16'h0749, 16'h3412},
		'{2'h0, 1'b1, 2'h3, 16'h3039, 2'h2, 16'h0084, 16'h3039, 16'h7333}};
	udp_sample_streamer i_udp_sample_streamer (
		.core_clk(core_clk), .arst_n(arst_n),
		.output_channel_select(ch), .rate_divisor_exponent(rate_exp),
		.ceiling_div_cycles(ceil_cyc), .sample_word_format(fmt),
		.packet_size_select(pk), .destination_port_number(port),
		.byte_order_and_check_bits(opt), .stream_on(stream_on), .enable_source_ip(src_ip),
		.x_in(x_in), .y_in(y_in), .r_in(r_in), .theta_in(theta_in),
		.x_float(32'h4120_1234), .y_float(32'h3F80_0000), .r_float(32'h4000_0000),
		.theta_float(32'hC000_0000), .rate_exp_readback(rate_exp_readback),
		.streaming(streaming), .overrun(overrun), .tx_valid(tx_valid), .tx_data(tx_data),
		.tx_first(tx_first), .tx_last(tx_last), .tx_ready(tx_ready), .dest_ip(dest_ip),
		.dest_port(dest_port), .check_enable(check_enable));
	udp_receiver_model i_udp_receiver_model (
		.core_clk(core_clk), .arst_n(arst_n), .tx_valid(tx_valid), .tx_data(tx_data),
		.tx_first(tx_first), .tx_last(tx_last), .tx_ready(tx_ready), .slow(slow),
		.pkt_len(pkt_len), .head_bytes(head_bytes), .pkt_count(pkt_count), .last_time(last_time));
	// 200 MHz clock
	always #2.5 core_clk = !core_clk;
	// hang guard
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 90000) begin
			fails++;
			results();
		end
	end
	// compares one value and reports a mismatch
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// turns streaming on and waits for one more packet
	task automatic run_pkt();
		logic [31:0] base;
		base = pkt_count;
		@(posedge core_clk) stream_on <= 1'b1;
		wait (pkt_count == base + 32'h0000_0001);
		@(posedge core_clk);
	endtask
	// turns streaming off and waits until the output is idle
	task automatic stop();
		@(posedge core_clk) stream_on <= 1'b0;
		repeat (3) @(posedge core_clk);
		while (tx_valid !== 1'b0 || streaming !== 1'b0) @(posedge core_clk);
		repeat (4) @(posedge core_clk);
	endtask
	// main sequence
	initial begin
		repeat (2) @(posedge core_clk);
		arst_n <= 1'b1;
		@(posedge core_clk);
		#1;
		check("reset port", dest_port, 16'h0749);
		check("reset check", check_enable, 1'b1);
		check("reset valid", tx_valid, 1'b0);
		for (int r = 0; r < 4; r++) begin
			@(posedge core_clk);
			ch <= rows[r].ch;
			fmt <= rows[r].fmt;
			pk <= rows[r].pk;
			port <= rows[r].port;
			opt <= rows[r].opt;
			slow <= r[0];
			src_ip <= 32'h0A00_0010 + r;
			run_pkt();
			check("payload length", pkt_len, rows[r].len);
			check("first data", head_bytes[15:0], rows[r].b45);
			check("port", dest_port, rows[r].eport);
			check("check bit", check_enable, rows[r].opt[1]);
			check("ip", dest_ip, src_ip);
			check("overrun", overrun, 1'b0);
			check("streaming", streaming, 1'b1);
			stop();
			check("stopped", streaming, 1'b0);
		end
		@(posedge core_clk);
		ch <= 2'h3;
		fmt <= 1'b1;
		pk <= 2'h3;
		port <= 16'h3039;
		opt <= 2'h0;
		rate_exp <= 5'h01;
		// a period under the floor must clamp to the 1.25 MHz ceiling
		ceil_cyc <= 16'h0050;
		run_pkt();
		t0 = last_time;
		seq0 = head_bytes[47:32];
		port <= 16'h07D0;
		rate_exp <= 5'h00;
		fmt <= 1'b0;
		run_pkt();
		check("packet gap", last_time - t0, 32'd5120);
		check("sequence", head_bytes[47:32], seq0 + 16'h0001);
		check("held port", dest_port, 16'h3039);
		check("held rate", rate_exp_readback, 5'h01);
		check("held format", head_bytes[15:8], 8'h73);
		stop();
		@(posedge core_clk) rate_exp <= 5'h19;
		@(posedge core_clk) stream_on <= 1'b1;
		repeat (4) @(posedge core_clk);
		check("clamped rate", rate_exp_readback, 5'h14);
		stop();
		results();
	end
endmodule
`default_nettype wire
